// *** rtl/rgft_regs.sv ***
// Rail group and fault response register bank.
// Assumes a synchronous 8-bit register port from the serial interface
// and fault inputs already in the clock_i domain.
`include "rgft_params.svh"

module rgft_regs #(
  parameter logic [7:0] CONV_DEFAULT = `RGFT_RESET_VALUE,
  parameter logic [7:0] MON_DEFAULT = `RGFT_RESET_VALUE,
  parameter logic [7:0] GRP_RESP_DEFAULT = `RGFT_RESET_VALUE,
  parameter logic [7:0] MOD_RESP_DEFAULT = `RGFT_RESET_VALUE
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [3:0] converter_fault_i,
  input wire logic [1:0] monitor_fault_i,
  input wire logic analog_fault_i,
  input wire logic severe_fault_i,
  input wire logic moderate_fault_i,
  output logic [7:0] reg_rdata_o,
  output logic [2:0] group_fault_o,
  output rgft_pkg::rgft_resp_t micro_group_response_o,
  output rgft_pkg::rgft_resp_t processor_group_response_o,
  output rgft_pkg::rgft_resp_t third_group_response_o,
  output rgft_pkg::rgft_resp_t severe_fault_response_o,
  output rgft_pkg::rgft_resp_t moderate_fault_response_o
);
  import rgft_pkg::*;

  rgft_state_t s_ff;
  rgft_state_t nxt_s;

  // ----------------------------------------
  // Group membership
  // ----------------------------------------
  // Returns a one-hot of groups hit by a faulting source; group 0 is none
  function automatic logic [2:0] grp_hit(input logic [1:0] sel,
                                         input logic flt);
    logic [2:0] h;
    h = 3'h0;
    if (flt && sel != RGFT_GRP_NONE) begin
      h[sel - 2'h1] = 1'b1;
    end
    return h;
  endfunction : grp_hit

  logic [2:0] hits;
  always_comb begin
    hits = 3'h0;
    for (int i = 0; i < 4; i++) begin
      hits |= grp_hit(s_ff.conv_grp_ff[2*i +: 2], converter_fault_i[i]);
    end
    hits |= grp_hit(s_ff.mon_grp_ff[`RGFT_POS_MON2 +: 2],
                    monitor_fault_i[1]);
    hits |= grp_hit(s_ff.mon_grp_ff[`RGFT_POS_MON1 +: 2],
                    monitor_fault_i[0]);
    hits |= grp_hit(s_ff.mon_grp_ff[`RGFT_POS_ANALOG +: 2],
                    analog_fault_i);
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nxt_s = s_ff;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        `RGFT_OFS_CONV_GRP: nxt_s.conv_grp_ff = reg_wdata_i;
        `RGFT_OFS_MON_GRP: nxt_s.mon_grp_ff = reg_wdata_i;
        `RGFT_OFS_GRP_RESP: nxt_s.grp_resp_ff = reg_wdata_i;
        `RGFT_OFS_MOD_RESP: nxt_s.mod_resp_ff = reg_wdata_i;
        default: nxt_s.rdata_ff = s_ff.rdata_ff;
      endcase
    end
    // Unmapped reads return zero so software sees a defined value
    nxt_s.rdata_ff = 8'h00;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `RGFT_OFS_CONV_GRP: nxt_s.rdata_ff = s_ff.conv_grp_ff;
        `RGFT_OFS_MON_GRP: nxt_s.rdata_ff = s_ff.mon_grp_ff;
        `RGFT_OFS_GRP_RESP: nxt_s.rdata_ff = s_ff.grp_resp_ff;
        `RGFT_OFS_MOD_RESP: nxt_s.rdata_ff = s_ff.mod_resp_ff;
        default: nxt_s.rdata_ff = 8'h00;
      endcase
    end
    nxt_s.grp_fault_ff = hits;
    nxt_s.micro_resp_ff = s_ff.grp_resp_ff[`RGFT_POS_MICRO +: 2];
    nxt_s.proc_resp_ff = s_ff.grp_resp_ff[`RGFT_POS_PROC +: 2];
    nxt_s.third_resp_ff = s_ff.grp_resp_ff[`RGFT_POS_THIRD +: 2];
    nxt_s.severe_resp_ff = s_ff.grp_resp_ff[`RGFT_POS_SEVERE +: 2];
    // Only bits 1:0 steer; reserved upper bits are storage only
    nxt_s.moderate_resp_ff = s_ff.mod_resp_ff[1:0];
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Nonvolatile defaults arrive as parameters, constant under reset
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s_ff <= '0;
      s_ff.conv_grp_ff <= CONV_DEFAULT;
      s_ff.mon_grp_ff <= MON_DEFAULT;
      s_ff.grp_resp_ff <= GRP_RESP_DEFAULT;
      s_ff.mod_resp_ff <= MOD_RESP_DEFAULT;
      s_ff.micro_resp_ff <= GRP_RESP_DEFAULT[1:0];
      s_ff.proc_resp_ff <= GRP_RESP_DEFAULT[3:2];
      s_ff.third_resp_ff <= GRP_RESP_DEFAULT[5:4];
      s_ff.severe_resp_ff <= GRP_RESP_DEFAULT[7:6];
      s_ff.moderate_resp_ff <= MOD_RESP_DEFAULT[1:0];
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign reg_rdata_o = s_ff.rdata_ff;
  assign group_fault_o = s_ff.grp_fault_ff;
  assign micro_group_response_o = rgft_resp_t'(s_ff.micro_resp_ff);
  assign processor_group_response_o = rgft_resp_t'(s_ff.proc_resp_ff);
  assign third_group_response_o = rgft_resp_t'(s_ff.third_resp_ff);
  assign severe_fault_response_o = rgft_resp_t'(s_ff.severe_resp_ff);
  assign moderate_fault_response_o = rgft_resp_t'(s_ff.moderate_resp_ff);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_conv_write;
    @(posedge clock_i) disable iff (rst_i)
      (reg_wr_i && reg_addr_i == `RGFT_OFS_CONV_GRP) ##1
      (reg_rd_i && !reg_wr_i && reg_addr_i == `RGFT_OFS_CONV_GRP)
      |=> reg_rdata_o == $past(reg_wdata_i, 2);
  endproperty
  a_conv_write: assert property (p_conv_write) else $error("conv rb");

  property p_mon2;
    @(posedge clock_i) disable iff (rst_i)
      (monitor_fault_i[1] && s_ff.mon_grp_ff[7:6] == 2'h2)
      |=> group_fault_o[1];
  endproperty
  a_mon2: assert property (p_mon2) else $error("mon2 group");

  property p_severe;
    @(posedge clock_i) disable iff (rst_i)
      (reg_wr_i && reg_addr_i == `RGFT_OFS_GRP_RESP) |=>
      ##1 severe_fault_response_o == $past(reg_wdata_i[7:6], 2);
  endproperty
  a_severe: assert property (p_severe) else $error("severe sel");

  // Checked from the bus side so a swapped field position is caught
  property p_third;
    @(posedge clock_i) disable iff (rst_i)
      (reg_wr_i && reg_addr_i == `RGFT_OFS_GRP_RESP) |=>
      ##1 third_group_response_o == $past(reg_wdata_i[5:4], 2);
  endproperty
  a_third: assert property (p_third) else $error("third sel");

  property p_proc;
    @(posedge clock_i) disable iff (rst_i)
      (reg_wr_i && reg_addr_i == `RGFT_OFS_GRP_RESP) |=>
      ##1 processor_group_response_o == $past(reg_wdata_i[3:2], 2);
  endproperty
  a_proc: assert property (p_proc) else $error("proc sel");

  property p_micro;
    @(posedge clock_i) disable iff (rst_i)
      (reg_wr_i && reg_addr_i == `RGFT_OFS_GRP_RESP) |=>
      ##1 micro_group_response_o == $past(reg_wdata_i[1:0], 2);
  endproperty
  a_micro: assert property (p_micro) else $error("micro sel");

  property p_moderate;
    @(posedge clock_i) disable iff (rst_i)
      (reg_wr_i && reg_addr_i == `RGFT_OFS_MOD_RESP) |=>
      ##1 moderate_fault_response_o == $past(reg_wdata_i[1:0], 2);
  endproperty
  a_moderate: assert property (p_moderate) else $error("mod sel");

  property p_none;
    @(posedge clock_i) disable iff (rst_i)
      (s_ff.conv_grp_ff == 8'h00 && s_ff.mon_grp_ff[7:2] == 6'h00)
      |=> group_fault_o == 3'h0;
  endproperty
  a_none: assert property (p_none) else $error("ungrouped hit");

  property p_conv1;
    @(posedge clock_i) disable iff (rst_i)
      (converter_fault_i[0] && s_ff.conv_grp_ff[1:0] == 2'h3)
      |=> group_fault_o[2];
  endproperty
  a_conv1: assert property (p_conv1) else $error("conv1 fault");

  property p_mon1;
    @(posedge clock_i) disable iff (rst_i)
      (monitor_fault_i[0] && s_ff.mon_grp_ff[5:4] == 2'h1)
      |=> group_fault_o[0];
  endproperty
  a_mon1: assert property (p_mon1) else $error("mon1 group");

  property p_analog;
    @(posedge clock_i) disable iff (rst_i)
      (analog_fault_i && s_ff.mon_grp_ff[3:2] == 2'h3)
      |=> group_fault_o[2];
  endproperty
  a_analog: assert property (p_analog) else $error("analog group");

  // Whole byte must return, reserved bits included
  property p_mod_rb;
    @(posedge clock_i) disable iff (rst_i)
      (reg_wr_i && reg_addr_i == `RGFT_OFS_MOD_RESP) ##1
      (reg_rd_i && !reg_wr_i && reg_addr_i == `RGFT_OFS_MOD_RESP)
      |=> reg_rdata_o == $past(reg_wdata_i, 2);
  endproperty
  a_mod_rb: assert property (p_mod_rb) else $error("mod rb");
endmodule : rgft_regs

// *** rtl/rgft_params.svh ***
// Constants for the rail group and fault response register bank.
// Assumes an 8-bit register port with 7-bit byte addresses.
`ifndef RGFT_PARAMS_SVH
`define RGFT_PARAMS_SVH
`define RGFT_OFS_CONV_GRP 7'h41
`define RGFT_OFS_MON_GRP 7'h43
`define RGFT_OFS_GRP_RESP 7'h44
`define RGFT_OFS_MOD_RESP 7'h45
`define RGFT_RESET_VALUE 8'h00
`define RGFT_POS_SEVERE 6
`define RGFT_POS_THIRD 4
`define RGFT_POS_PROC 2
`define RGFT_POS_MICRO 0
`define RGFT_POS_MON2 6
`define RGFT_POS_MON1 4
`define RGFT_POS_ANALOG 2
`endif

// *** rtl/rgft_pkg.sv ***
// Types for the rail group and fault response register bank.
// Assumes nothing beyond the params header.
package rgft_pkg;
  typedef enum logic [1:0] {
    RGFT_GRP_NONE = 2'h0,
    RGFT_GRP_MICRO = 2'h1,
    RGFT_GRP_PROC = 2'h2,
    RGFT_GRP_THIRD = 2'h3
  } rgft_group_t;
  typedef enum logic [1:0] {
    RGFT_RESP_IMMEDIATE = 2'h0,
    RGFT_RESP_ORDERLY = 2'h1,
    RGFT_RESP_MICRO_ERR = 2'h2,
    RGFT_RESP_PROC_ERR = 2'h3
  } rgft_resp_t;
  typedef struct packed {
    logic [7:0] conv_grp_ff;
    logic [7:0] mon_grp_ff;
    logic [7:0] grp_resp_ff;
    logic [7:0] mod_resp_ff;
    logic [7:0] rdata_ff;
    logic [2:0] grp_fault_ff;
    logic [1:0] micro_resp_ff;
    logic [1:0] proc_resp_ff;
    logic [1:0] third_resp_ff;
    logic [1:0] severe_resp_ff;
    logic [1:0] moderate_resp_ff;
  } rgft_state_t;
endpackage : rgft_pkg

// *** bench/rgft_tb.sv ***
// Self-checking bench for the rail group and fault response bank.
// Assumes rgft_pkg and rgft_regs are compiled first; 50 ns clock.
// ----------------------------------------------------------------
// Bench top
// ----------------------------------------------------------------
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import rgft_pkg::*;
  logic clock, rst, wr, rd, afl, sev, mdf;
  logic [6:0] addr;
  logic [7:0] wdata, rdata;
  logic [3:0] cfl;
  logic [1:0] mfl;
  logic [2:0] gf;
  rgft_resp_t mr, pr, tr, sr, dr;
  int failures, compares;
  rgft_regs dut (.clock_i(clock), .rst_i(rst), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
    .converter_fault_i(cfl), .monitor_fault_i(mfl),
    .analog_fault_i(afl), .severe_fault_i(sev),
    .moderate_fault_i(mdf), .reg_rdata_o(rdata), .group_fault_o(gf),
    .micro_group_response_o(mr), .processor_group_response_o(pr),
    .third_group_response_o(tr), .severe_fault_response_o(sr),
    .moderate_fault_response_o(dr));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  // Source order: converters 1..4, monitor one, monitor two, analog
  function automatic logic [2:0] exp_gf(logic [7:0] c, logic [7:0] m,
                                        logic [6:0] h);
    logic [2:0] r;
    logic [1:0] g;
    r = 3'h0;
    for (int i = 0; i < 7; i++) begin
      g = (i < 4) ? c[2*i+:2] : m[((i == 6) ? 2 : 2*i-4)+:2];
      if (g != 2'h0 && h[i]) r[g-1] = 1'b1;
    end
    return r;
  endfunction : exp_gf
  task automatic wr_reg(logic [6:0] a, logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
  endtask : wr_reg
  task automatic rd_reg(logic [6:0] a, logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    check("rdata", rdata, e);
    @(posedge clock);
  endtask : rd_reg
  // Read in the cycle right after the write: new value must show
  task automatic wr_rd(logic [6:0] a, logic [7:0] d);
    wr_reg(a, d);
    wr <= 1'b0;
    rd_reg(a, d);
  endtask : wr_rd
  // Reset mid-run must bring back defaults even after writes
  task automatic pulse_reset(int n);
    rst <= 1'b1;
    repeat (n) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    check("reset_resp", {sr, tr, pr, mr}, 8'h00);
    check("reset_mod", {6'h0, dr}, 8'h00);
    check("reset_gf", {5'h0, gf}, 8'h00);
    check("reset_rdata", rdata, 8'h00);
    @(posedge clock);
    rd_reg(7'h41, 8'h00);
    rd_reg(7'h43, 8'h00);
    rd_reg(7'h44, 8'h00);
    rd_reg(7'h45, 8'h00);
  endtask : pulse_reset
  // Writes all four registers back to back, so ordering hazards show
  task automatic apply(logic [7:0] c, m, g, d, logic [6:0] h);
    {afl, mfl, cfl} <= h;
    wr_reg(7'h41, c);
    wr_reg(7'h43, m);
    wr_reg(7'h44, g);
    wr_reg(7'h45, d);
    wr <= 1'b0;
    repeat (2) @(posedge clock);
    @(negedge clock);
    check("group_fault", {5'h0, gf}, {5'h0, exp_gf(c, m, h)});
    check("severe", {6'h0, sr}, {6'h0, g[7:6]});
    check("third", {6'h0, tr}, {6'h0, g[5:4]});
    check("processor", {6'h0, pr}, {6'h0, g[3:2]});
    check("micro", {6'h0, mr}, {6'h0, g[1:0]});
    check("moderate", {6'h0, dr}, {6'h0, d[1:0]});
    @(posedge clock);
    rd_reg(7'h41, c);
    rd_reg(7'h43, m);
    rd_reg(7'h44, g);
    rd_reg(7'h45, d);
  endtask : apply
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    stop_test();
  end
  initial begin
    {wr, rd, afl, sev, mdf, cfl, mfl} = '0;
    addr = 7'h00;
    wdata = 8'h00;
    failures = 0;
    compares = 0;
    void'($urandom(42));
    pulse_reset(3);
    // Unmapped place: write is dropped, read gives zero
    wr_reg(7'h42, 8'h5a);
    wr <= 1'b0;
    rd_reg(7'h42, 8'h00);
    rd_reg(7'h41, 8'h00);
    rd_reg(7'h43, 8'h00);
    // Every group and response code, reserved bits set to ones
    for (int v = 0; v < 4; v++) begin
      apply({4{v[1:0]}}, {{3{v[1:0]}}, 2'h3}, {4{v[1:0]}},
            {6'h3f, v[1:0]}, 7'h7f);
    end
    for (int n = 0; n < 40; n++) begin
      wr_rd(7'h41, 8'($urandom));
      wr_rd(7'h45, 8'($urandom));
      apply(8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom),
            7'($urandom));
    end
    pulse_reset(2);
    apply(8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom),
          7'($urandom));
    stop_test();
  end
endmodule : testbench
